/* File: hdl/scss_device.sv */
`timescale 1ns/1ps
`include "scss_params.svh"

// Function
// - mode code zero async, else count 4n
// - count both half-cycles of rectified input
// - strobe fall before count ends forces hold
// - successive strobes sample detectors A..D
// - select pulse rise steps output A..D
// - servo reset low clears logic, output reference
// - gate high, standby low fires 500ns reset
// - serial pins honoured only while enable low
// - eight data then four address bits, LSB first
// - host parks data low unclocked to write
// - enable rise after write latches byte
// - seven byte registers drive control words
// - host sends address then unclocked high for read
// - enable rise after read drives bit zero
// - each serial clock rise shifts next bit out
// - data low then enable rise ends read
// - servo gate picks servo or data words
// - async mode tracks while strobe high
// - sync mode starts on falling zero crossing
// - mode field bits 7:5 of address 1011
module scss_device #(
   parameter int ONESHOT_CYC = `SCSS_ONESHOT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   scss_if.dev link,
   input wire logic zero_cross_i,
   output scss_pkg::scss_byte_t cutoff_word_o,
   output logic [3:0] boost_word_o,
   output scss_pkg::scss_word5_t gain_word_o,
   output scss_pkg::scss_word5_t lvlq_word_o,
   output scss_pkg::scss_word5_t peak_word_o,
   output logic [3:0] track_o,
   output logic [1:0] out_sel_o,
   output logic servo_out_ref_o
);
   import scss_pkg::*;

   localparam int SHOT_W = $clog2(ONESHOT_CYC + 1);

   logic [`SCSS_PIN_COUNT-1:0] pin_raw;
   logic [`SCSS_PIN_COUNT-1:0] pin;
   logic [`SCSS_PIN_COUNT-1:0] pin_d;
   logic sdi, sclk_rise, en_n, en_fall, en_rise;
   logic stby_n, gate, srst_n, sel_rise, strobe, strobe_rise, strobe_fall;
   logic zc_fall, zc_edge;
   scss_link_e state;
   logic [`SCSS_FRAME_BITS-1:0] sr;
   logic [`SCSS_FRAME_BITS-1:0] out_sr;
   logic [3:0] cnt;
   scss_byte_t regs [0:`SCSS_REG_COUNT-1];
   logic [2:0] mode;
   logic [4:0] term;
   logic [SHOT_W-1:0] shot;
   logic auto_d, blk_rst;
   logic [1:0] det;
   logic armed, tracking;
   logic [4:0] cyc;
   logic sel_first;
   scss_byte_t rd_byte;

   if (ONESHOT_CYC < 1) $error("scss_device: ONESHOT_CYC below 1");

   function automatic logic reg_hit(input scss_addr_t a);
      reg_hit = (a >= `SCSS_REG_FIRST) &&
         (a < `SCSS_REG_FIRST + 4'(`SCSS_REG_COUNT));
   endfunction

   function automatic logic [2:0] reg_idx(input scss_addr_t a);
      reg_idx = 3'(a - `SCSS_REG_FIRST);
   endfunction

   function automatic scss_byte_t reg_read(input scss_addr_t a);
      reg_read = reg_hit(a) ? regs[reg_idx(a)] : 8'h00;
   endfunction

   // byte addressed by the shifted address bits, for read-back
   always_comb begin
      rd_byte = reg_read(sr[11:8]);
   end

   // ****************************************************************
   // pin sampling
   // ****************************************************************
   assign pin_raw = {link.serial_data_in, link.serial_clock,
      link.serial_enable_n, link.standby_n, link.servo_gate,
      link.servo_reset_n, link.output_select_pulse, link.strobe_a,
      zero_cross_i};

   scss_sync #(.WIDTH(`SCSS_PIN_COUNT), .IDLE(`SCSS_PIN_IDLE)) u_pin_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(pin_raw),
      .level_o(pin),
      .prev_o(pin_d)
   );

   assign sdi = pin[8];
   assign en_n = pin[6];
   assign sclk_rise = pin[7] && !pin_d[7] && !en_n;
   assign en_fall = !pin[6] && pin_d[6];
   assign en_rise = pin[6] && !pin_d[6];
   assign stby_n = pin[5];
   assign gate = pin[4];
   assign srst_n = pin[3];
   assign sel_rise = pin[2] && !pin_d[2];
   assign strobe = pin[1];
   assign strobe_rise = pin[1] && !pin_d[1];
   assign strobe_fall = !pin[1] && pin_d[1];
   assign zc_fall = !pin[0] && pin_d[0];
   assign zc_edge = pin[0] != pin_d[0];

   // ****************************************************************
   // serial link
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state <= LK_IDLE;
         sr <= '0;
         out_sr <= '0;
         cnt <= 4'h0;
         link.serial_data_out <= 1'b0;
         link.serial_data_out_oe_n <= 1'b1;
      end else begin
         case (state)
            LK_IDLE: begin
               if (en_fall) begin
                  cnt <= 4'h0;
                  state <= LK_SHIFT;
               end
            end
            LK_SHIFT: begin
               if (sclk_rise && cnt != 4'(`SCSS_FRAME_BITS)) begin
                  sr <= {sdi, sr[`SCSS_FRAME_BITS-1:1]};
                  cnt <= cnt + 4'h1;
               end
               if (en_rise) begin
                  if (sdi && cnt == 4'(`SCSS_ADDR_BITS)) begin
                     out_sr <= {sr[11:8], rd_byte};
                     link.serial_data_out <= rd_byte[0];
                     link.serial_data_out_oe_n <= 1'b0;
                     state <= LK_RD_WAIT;
                  end else begin
                     state <= LK_IDLE;
                  end
               end
            end
            LK_RD_WAIT: begin
               if (en_fall) begin
                  state <= LK_RD_OUT;
               end
            end
            LK_RD_OUT: begin
               if (sclk_rise) begin
                  out_sr <= out_sr >> 1;
                  link.serial_data_out <= out_sr[1];
               end
               if (en_rise) begin
                  link.serial_data_out_oe_n <= 1'b1;
                  state <= LK_IDLE;
               end
            end
            default: state <= LK_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < `SCSS_REG_COUNT; i++) begin
            regs[i] <= `SCSS_REG_RESET;
         end
      end else if (state == LK_SHIFT && en_rise && !sdi &&
                   cnt == 4'(`SCSS_FRAME_BITS) && reg_hit(sr[11:8])) begin
         regs[reg_idx(sr[11:8])] <= sr[7:0];
      end
   end

   // ****************************************************************
   // control words, cutoff, boost and gain chosen by servo gate
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cutoff_word_o <= 8'h00;
         boost_word_o <= 4'h0;
         gain_word_o <= 5'h00;
         lvlq_word_o <= 5'h00;
         peak_word_o <= 5'h00;
      end else begin
         cutoff_word_o <= gate ? reg_read(`SCSS_ADDR_CUT_SERVO) :
            reg_read(`SCSS_ADDR_CUT_DATA);
         boost_word_o <= gate ?
            regs[reg_idx(`SCSS_ADDR_BOOST)][`SCSS_BOOST_SERVO_MSB:
                                            `SCSS_BOOST_SERVO_LSB] :
            regs[reg_idx(`SCSS_ADDR_BOOST)][`SCSS_BOOST_DATA_MSB:0];
         gain_word_o <= gate ?
            regs[reg_idx(`SCSS_ADDR_MODE)][`SCSS_WORD5_MSB:0] :
            regs[reg_idx(`SCSS_ADDR_GAIN_DATA)][`SCSS_WORD5_MSB:0];
         lvlq_word_o <= regs[reg_idx(`SCSS_ADDR_LVLQ)][`SCSS_WORD5_MSB:0];
         peak_word_o <= regs[reg_idx(`SCSS_ADDR_PEAK)][`SCSS_WORD5_MSB:0];
      end
   end

   // ****************************************************************
   // servo reset and auto-reset one-shot
   // ****************************************************************
   assign mode =
      regs[reg_idx(`SCSS_ADDR_MODE)][`SCSS_MODE_MSB:`SCSS_MODE_LSB];
   assign term = {mode, 2'b00};
   assign blk_rst = srst_i || !srst_n || shot != '0;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         auto_d <= 1'b0;
         shot <= '0;
      end else begin
         auto_d <= gate && !stby_n;
         if (gate && !stby_n && !auto_d) begin
            shot <= SHOT_W'(ONESHOT_CYC);
         end else if (shot != '0) begin
            shot <= shot - SHOT_W'(1);
         end
      end
   end

   // ****************************************************************
   // demodulation sequencer
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         det <= 2'h0;
         armed <= 1'b0;
         tracking <= 1'b0;
         cyc <= 5'h00;
      end else if (strobe_fall) begin
         tracking <= 1'b0;
         armed <= 1'b0;
         det <= det + 2'h1;
      end else if (mode == 3'h0) begin
         tracking <= strobe;
      end else if (strobe_rise) begin
         armed <= 1'b1;
         cyc <= 5'h00;
      end else if (armed && zc_fall) begin
         armed <= 1'b0;
         tracking <= 1'b1;
      end else if (tracking && zc_edge) begin
         cyc <= cyc + 5'h01;
         if (cyc + 5'h01 == term) begin
            tracking <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // output select and servo outputs
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (blk_rst) begin
         out_sel_o <= 2'h0;
         sel_first <= 1'b1;
      end else if (sel_rise) begin
         out_sel_o <= sel_first ? 2'h0 : out_sel_o + 2'h1;
         sel_first <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         track_o <= 4'h0;
         servo_out_ref_o <= 1'b1;
      end else begin
         track_o <= tracking ? 4'(4'h1 << det) : 4'h0;
         servo_out_ref_o <= blk_rst;
      end
   end
endmodule

/* File: hdl/scss_params.svh */
`ifndef SCSS_PARAMS_SVH
`define SCSS_PARAMS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define SCSS_SYS_CLK_KHZ 20000
`define SCSS_ONESHOT_NS 500
`define SCSS_ONESHOT_CYC ((`SCSS_ONESHOT_NS * `SCSS_SYS_CLK_KHZ) / 1000000)
`define SCSS_SCLK_HALF_CYC 4

// ****************************************************************
// serial frame
// ****************************************************************
`define SCSS_DATA_BITS 8
`define SCSS_ADDR_BITS 4
`define SCSS_FRAME_BITS 12
`define SCSS_CYC_PER_CODE 4

// ****************************************************************
// register map and fields
// ****************************************************************
`define SCSS_REG_COUNT 7
`define SCSS_REG_FIRST 4'h8
`define SCSS_REG_RESET 8'h00
`define SCSS_ADDR_CUT_DATA 4'h8
`define SCSS_ADDR_CUT_SERVO 4'h9
`define SCSS_ADDR_BOOST 4'hA
`define SCSS_ADDR_MODE 4'hB
`define SCSS_ADDR_GAIN_DATA 4'hC
`define SCSS_ADDR_LVLQ 4'hD
`define SCSS_ADDR_PEAK 4'hE
`define SCSS_MODE_MSB 7
`define SCSS_MODE_LSB 5
`define SCSS_BOOST_DATA_MSB 3
`define SCSS_BOOST_SERVO_MSB 7
`define SCSS_BOOST_SERVO_LSB 4
`define SCSS_WORD5_MSB 4

// ****************************************************************
// pin sampling: {sdi, sclk, en_n, stby_n, gate, srst_n, sel, strobe, zc}
// ****************************************************************
`define SCSS_PIN_COUNT 9
`define SCSS_PIN_IDLE 9'h068

`endif

/* File: hdl/scss_pkg.sv */
`include "scss_params.svh"

package scss_pkg;
   typedef logic [`SCSS_DATA_BITS-1:0] scss_byte_t;
   typedef logic [`SCSS_ADDR_BITS-1:0] scss_addr_t;
   typedef logic [4:0] scss_word5_t;
   typedef enum {LK_IDLE, LK_SHIFT, LK_RD_WAIT, LK_RD_OUT} scss_link_e;
   typedef enum {HC_IDLE, HC_SETUP, HC_HI, HC_LO, HC_MARK, HC_CLOSE,
      HC_OPEN, HC_SAMP, HC_RHI, HC_RLO, HC_END, HC_END2} scss_host_e;
endpackage

/* File: hdl/scss_if.sv */
`timescale 1ns/1ps

interface scss_if;
   logic serial_enable_n;
   logic serial_clock;
   logic serial_data_in;
   logic serial_data_out;
   logic serial_data_out_oe_n;
   logic strobe_a;
   logic output_select_pulse;
   logic servo_reset_n;
   logic servo_gate;
   logic standby_n;
   wire serial_data_line;

   // ****************************************************************
   // resolved level of the three-state serial output
   // ****************************************************************
   // released line idles high, as a pulled-up pin would
   assign serial_data_line = serial_data_out_oe_n ? 1'b1 : serial_data_out;

   modport dev (
      input serial_enable_n, serial_clock, serial_data_in, strobe_a,
      input output_select_pulse, servo_reset_n, servo_gate, standby_n,
      output serial_data_out, serial_data_out_oe_n
   );
   modport host (
      output serial_enable_n, serial_clock, serial_data_in, strobe_a,
      output output_select_pulse, servo_reset_n, servo_gate, standby_n,
      input serial_data_line
   );
endinterface

/* File: hdl/scss_sync.sv */
`timescale 1ns/1ps
`include "scss_params.svh"

module scss_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE = '0
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] prev_o
);
   logic [WIDTH-1:0] stage1;

   if (WIDTH < 1) $error("scss_sync: WIDTH must be at least 1");

   // ****************************************************************
   // two-flop synchroniser plus one delay stage for edge detection
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         stage1 <= IDLE;
         level_o <= IDLE;
         prev_o <= IDLE;
      end else begin
         stage1 <= async_i;
         level_o <= stage1;
         prev_o <= level_o;
      end
   end
endmodule

/* File: hdl/scss_ctrl.sv */
`timescale 1ns/1ps
`include "scss_params.svh"

module scss_ctrl #(
   parameter int SCLK_HALF = `SCSS_SCLK_HALF_CYC
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   scss_if.host link,
   input wire logic wr_req_i,
   input wire logic rd_req_i,
   input wire scss_pkg::scss_addr_t addr_i,
   input wire scss_pkg::scss_byte_t data_i,
   input wire logic strobe_i,
   input wire logic sel_pulse_i,
   input wire logic servo_reset_n_i,
   input wire logic servo_gate_i,
   input wire logic standby_n_i,
   output logic busy_o,
   output logic rd_valid_o,
   output scss_pkg::scss_byte_t rd_data_o,
   output scss_pkg::scss_addr_t rd_addr_o
);
   import scss_pkg::*;

   scss_host_e state;
   logic [7:0] tmr;
   logic tick;
   logic is_read;
   logic [3:0] cnt;
   logic [`SCSS_FRAME_BITS-1:0] tx_sr;
   logic [`SCSS_FRAME_BITS-1:0] rx_sr;
   logic sdo_sync;

   if (SCLK_HALF < 4 || SCLK_HALF > 255)
      $error("scss_ctrl: SCLK_HALF must be 4..255");

   scss_sync #(.WIDTH(1), .IDLE(1'b1)) u_sdo_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(link.serial_data_line),
      .level_o(sdo_sync),
      .prev_o()
   );

   // ****************************************************************
   // serial clock divider: one step per half period
   // ****************************************************************
   assign tick = (tmr == 8'h00);

   always_ff @(posedge sys_clk_i) begin
      if (srst_i || state == HC_IDLE) begin
         tmr <= 8'(SCLK_HALF - 1);
      end else if (tick) begin
         tmr <= 8'(SCLK_HALF - 1);
      end else begin
         tmr <= tmr - 8'h01;
      end
   end

   // ****************************************************************
   // servo strobes pass straight through registers
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         link.strobe_a <= 1'b0;
         link.output_select_pulse <= 1'b0;
         link.servo_reset_n <= 1'b1;
         link.servo_gate <= 1'b0;
         link.standby_n <= 1'b1;
      end else begin
         link.strobe_a <= strobe_i;
         link.output_select_pulse <= sel_pulse_i;
         link.servo_reset_n <= servo_reset_n_i;
         link.servo_gate <= servo_gate_i;
         link.standby_n <= standby_n_i;
      end
   end

   // ****************************************************************
   // transfer sequencer
   // ****************************************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state <= HC_IDLE;
         link.serial_enable_n <= 1'b1;
         link.serial_clock <= 1'b0;
         link.serial_data_in <= 1'b0;
         is_read <= 1'b0;
         cnt <= 4'h0;
         tx_sr <= '0;
         rx_sr <= '0;
         busy_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= 8'h00;
         rd_addr_o <= 4'h0;
      end else begin
         rd_valid_o <= 1'b0;
         case (state)
            HC_IDLE: begin
               if (wr_req_i || rd_req_i) begin
                  // write: data LSB first then address; read: address only
                  link.serial_enable_n <= 1'b0;
                  is_read <= rd_req_i && !wr_req_i;
                  tx_sr <= wr_req_i ? {addr_i, data_i} : {8'h00, addr_i};
                  cnt <= wr_req_i ? 4'hC : 4'h4;
                  busy_o <= 1'b1;
                  state <= HC_SETUP;
               end
            end
            HC_SETUP: if (tick) begin
               link.serial_data_in <= tx_sr[0];
               state <= HC_HI;
            end
            HC_HI: if (tick) begin
               link.serial_clock <= 1'b1;
               state <= HC_LO;
            end
            HC_LO: if (tick) begin
               link.serial_clock <= 1'b0;
               tx_sr <= tx_sr >> 1;
               cnt <= cnt - 4'h1;
               state <= (cnt == 4'h1) ? HC_MARK : HC_SETUP;
            end
            HC_MARK: if (tick) begin
               link.serial_data_in <= is_read;
               state <= HC_CLOSE;
            end
            HC_CLOSE: if (tick) begin
               link.serial_enable_n <= 1'b1;
               if (is_read) begin
                  state <= HC_OPEN;
               end else begin
                  busy_o <= 1'b0;
                  state <= HC_IDLE;
               end
            end
            HC_OPEN: if (tick) begin
               link.serial_enable_n <= 1'b0;
               cnt <= 4'hC;
               state <= HC_SAMP;
            end
            HC_SAMP: if (tick) begin
               rx_sr <= {sdo_sync, rx_sr[`SCSS_FRAME_BITS-1:1]};
               cnt <= cnt - 4'h1;
               state <= (cnt == 4'h1) ? HC_END : HC_RHI;
            end
            HC_RHI: if (tick) begin
               link.serial_clock <= 1'b1;
               state <= HC_RLO;
            end
            HC_RLO: if (tick) begin
               link.serial_clock <= 1'b0;
               state <= HC_SAMP;
            end
            HC_END: if (tick) begin
               link.serial_data_in <= 1'b0;
               state <= HC_END2;
            end
            HC_END2: if (tick) begin
               link.serial_enable_n <= 1'b1;
               rd_data_o <= rx_sr[7:0];
               rd_addr_o <= rx_sr[11:8];
               rd_valid_o <= 1'b1;
               busy_o <= 1'b0;
               state <= HC_IDLE;
            end
            default: state <= HC_IDLE;
         endcase
      end
   end
endmodule

/* File: sim/scss_chk.sv */
`timescale 1ns/1ps

module scss_chk (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic serial_enable_n,
   input wire logic serial_clock,
   input wire logic serial_data_in,
   input wire logic serial_data_out_oe_n
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   // ****
   // link framing
   // ****
   sequence s_rd_mark;
      $rose(serial_enable_n) && serial_data_in && serial_data_out_oe_n;
   endsequence
   sequence s_clk_up;
      $rose(serial_clock);
   endsequence
   sequence s_rd_close;
      $rose(serial_enable_n) && !serial_data_out_oe_n;
   endsequence

   AST_CLK_EN: assert property (serial_clock |-> !serial_enable_n)
      else $error("serial clock high with enable off");
   AST_CLK_HIGH: assert property (
      s_clk_up |-> serial_clock [*4] ##1 !serial_clock)
      else $error("serial clock high phase wrong");
   AST_DATA_HOLD: assert property (
      serial_clock && $past(serial_clock) |-> $stable(serial_data_in))
      else $error("serial data moved while clock high");
   AST_MARK_UNCLK: assert property (
      $rose(serial_enable_n) |-> !serial_clock && !$past(serial_clock))
      else $error("clock edge at transfer end");
   AST_RD_DRIVE: assert property (
      s_rd_mark |-> ##[1:8] !serial_data_out_oe_n)
      else $error("read output not driven");
   AST_DRIVE_LATE: assert property (
      $fell(serial_data_out_oe_n) |->
         serial_enable_n && $past(serial_enable_n))
      else $error("output driven while enabled");
   AST_RD_END: assert property (
      s_rd_close |-> !serial_data_in ##[1:8] serial_data_out_oe_n)
      else $error("read end not released");
   AST_HIZ_OPEN: assert property (
      $fell(serial_enable_n) && serial_data_out_oe_n |->
         serial_data_out_oe_n [*8])
      else $error("output driven in address phase");
endmodule

/* File: sim/scss_tb_top.sv */
`timescale 1ns/1ps

module scss_tb_top;
   import scss_pkg::*;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic wr_req, rd_req, strobe, sel, srst_n, gate, stby_n, zc;
   logic busy, rd_valid, ref_o;
   logic [3:0] boost, track;
   logic [1:0] osel;
   logic [11:0] wire_bits;
   scss_addr_t addr, rd_addr;
   scss_byte_t data, rd_data, cut, cut_b;
   scss_word5_t gain, lvlq, peak;
   int n_fail = 0;
   int check_count = 0;
   int i;
   scss_if link_if ();
   scss_if bad_if ();

   scss_ctrl i_scss_ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .link(link_if), .wr_req_i(wr_req), .rd_req_i(rd_req), .addr_i(addr),
      .data_i(data), .strobe_i(strobe), .sel_pulse_i(sel),
      .servo_reset_n_i(srst_n), .servo_gate_i(gate), .standby_n_i(stby_n),
      .busy_o(busy), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
      .rd_addr_o(rd_addr));
   scss_device i_scss_device (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .link(link_if), .zero_cross_i(zc), .cutoff_word_o(cut),
      .boost_word_o(boost), .gain_word_o(gain), .lvlq_word_o(lvlq),
      .peak_word_o(peak), .track_o(track), .out_sel_o(osel),
      .servo_out_ref_o(ref_o));
   scss_device i_scss_device_b (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .link(bad_if), .zero_cross_i(1'b0), .cutoff_word_o(cut_b),
      .boost_word_o(), .gain_word_o(), .lvlq_word_o(), .peak_word_o(),
      .track_o(), .out_sel_o(), .servo_out_ref_o());
   scss_chk i_scss_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .serial_enable_n(link_if.serial_enable_n),
      .serial_clock(link_if.serial_clock),
      .serial_data_in(link_if.serial_data_in),
      .serial_data_out_oe_n(link_if.serial_data_out_oe_n));

   // ****
   // tasks
   // ****
   initial forever #25 sys_clk_i = ~sys_clk_i;
   always @(posedge link_if.serial_clock) begin
      wire_bits <= {link_if.serial_data_in, wire_bits[11:1]};
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic request(input scss_addr_t a, input logic wr);
      int k;
      addr = a;
      wr_req = wr;
      rd_req = ~wr;
      cyc(1);
      wr_req = 1'b0;
      rd_req = 1'b0;
      for (k = 0; k < 4 && busy !== 1'b1; k++) cyc(1);
      for (k = 0; k < 2000 && busy !== 1'b0; k++) cyc(1);
   endtask

   task automatic write_reg(input scss_addr_t a, input scss_byte_t d);
      data = d;
      request(a, 1'b1);
      check(wire_bits[7:0], d);
      check(8'(wire_bits[11:8]), 8'(a));
      check(8'(link_if.serial_data_out_oe_n), 8'h01);
   endtask

   task automatic read_reg(input scss_addr_t a, input scss_byte_t d);
      int k;
      request(a, 1'b0);
      check(8'(rd_valid), 8'h01);
      check(rd_data, d);
      check(8'(rd_addr), 8'(a));
   endtask

   task automatic raw_frame(input int n, input logic [11:0] v);
      int k;
      bad_if.serial_enable_n = 1'b0;
      cyc(4);
      for (k = 0; k < n; k++) begin
         bad_if.serial_data_in = v[k];
         cyc(4);
         bad_if.serial_clock = 1'b1;
         cyc(4);
         bad_if.serial_clock = 1'b0;
      end
      cyc(4);
      bad_if.serial_data_in = 1'b0;
      cyc(4);
      bad_if.serial_enable_n = 1'b1;
      cyc(8);
   endtask

   task automatic zc_edges(input int n);
      repeat (n) begin
         zc = ~zc;
         cyc(6);
      end
   endtask

   // ****
   // tests
   // ****
   initial begin
      #(40000 * 50);
      n_fail++;
      complete_run();
   end

   initial begin
      {wr_req, rd_req, strobe, sel, gate, zc, addr, data} = '0;
      {srst_n, stby_n} = 2'b11;
      bad_if.serial_enable_n = 1'b1;
      bad_if.serial_clock = 1'b0;
      bad_if.serial_data_in = 1'b0;
      {bad_if.strobe_a, bad_if.output_select_pulse} = 2'b00;
      {bad_if.servo_gate, bad_if.servo_reset_n} = 2'b01;
      bad_if.standby_n = 1'b1;
      cyc(3);
      srst_i = 1'b0;
      cyc(1);
      for (i = 8; i < 15; i++) write_reg(i[3:0], {~i[3:0], i[3:0]});
      for (i = 8; i < 15; i++) read_reg(i[3:0], {~i[3:0], i[3:0]});
      write_reg(4'h3, 8'h5A);
      read_reg(4'h3, 8'h00);
      cyc(8);
      check(cut, 8'h78);
      check(8'(boost), 8'h0A);
      check(8'(gain), 8'h1C);
      check(8'(lvlq), 8'h0D);
      check(8'(peak), 8'h1E);
      gate = 1'b1;
      cyc(8);
      check(cut, 8'h69);
      check(8'(boost), 8'h05);
      check(8'(gain), 8'h0B);
      gate = 1'b0;
      $display("test registers done");
      raw_frame(11, 12'h85A);
      check(cut_b, 8'h00);
      raw_frame(12, 12'h85A);
      check(cut_b, 8'h5A);
      $display("test framing done");
      for (i = 0; i < 5; i++) begin
         sel = 1'b1;
         cyc(6);
         sel = 1'b0;
         cyc(6);
         check(8'(osel), 8'(i % 4));
      end
      write_reg(4'hB, 8'h00);
      for (i = 0; i < 5; i++) begin
         strobe = 1'b1;
         cyc(8);
         check(8'(track), 8'(4'h1 << (i % 4)));
         strobe = 1'b0;
         cyc(8);
         check(8'(track), 8'h00);
      end
      write_reg(4'hB, 8'h20);
      strobe = 1'b1;
      cyc(8);
      check(8'(track), 8'h00);
      zc_edges(2);
      check(8'(track), 8'h02);
      zc_edges(1);
      check(8'(track), 8'h02);
      zc_edges(3);
      check(8'(track), 8'h00);
      strobe = 1'b0;
      cyc(8);
      write_reg(4'hB, 8'hE0);
      strobe = 1'b1;
      cyc(8);
      zc_edges(4);
      check(8'(track), 8'h04);
      strobe = 1'b0;
      cyc(6);
      check(8'(track), 8'h00);
      $display("test servo done");
      sel = 1'b1;
      cyc(6);
      sel = 1'b0;
      cyc(6);
      check(8'(osel), 8'h01);
      srst_n = 1'b0;
      cyc(8);
      check(8'(ref_o), 8'h01);
      check(8'(osel), 8'h00);
      srst_n = 1'b1;
      cyc(8);
      check(8'(ref_o), 8'h00);
      stby_n = 1'b0;
      gate = 1'b1;
      cyc(6);
      check(8'(ref_o), 8'h01);
      cyc(20);
      check(8'(ref_o), 8'h00);
      $display("test reset done");
      complete_run();
   end
endmodule
